// ---- include/host_access_pkg.sv ----
// Shared constants and types for the slave-mode host access block.
package host_access_pkg;
  // Register byte addresses on the AXI4-Lite port.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // Field positions in the system control register.
  localparam int SYNC_MODE_POS = 0;
  localparam int EXTRA_WAIT_POS = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Field positions in the status register.
  localparam int ST_SLAVE_POS = 0;
  localparam int ST_SERIAL_POS = 1;
  localparam int ST_INDEP_POS = 2;
  // Idle pin levels loaded into the synchronisers: core enabled, strobe high, read.
  localparam logic [20:0] PIN_IDLE = 21'h0c0000;
  // Wait states per access timing.
  localparam logic [2:0] ASYNC_WAITS = 3'h3;
  localparam logic [2:0] SYNC_WRITE_WAITS = 3'h0;
  localparam logic [2:0] SYNC_READ_WAITS = 3'h0;
  localparam logic [2:0] EXTRA_READ_WAITS = 3'h1;
  // Bits moved per serial DMA memory cycle.
  localparam logic [4:0] FRAMED_BITS = 5'h10;
  localparam logic [4:0] OTHER_RX_BITS = 5'h08;
  localparam logic [4:0] OTHER_TX_BITS = 5'h10;
  // External master word addresses.
  localparam logic [1:0] EXT_CTRL_ADDR = 2'h0;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {W_IDLE, W_COUNT} wait_state_type;
endpackage

// ---- include/wait_if.sv ----
// Carrier between the access front end and the wait-state counter.
`timescale 1ns/1ns
interface wait_if;
  logic start;
  logic [2:0] waits;
  logic done;
  modport requester(output start, output waits, input done);
  modport counter(input start, input waits, output done);
endinterface

// ---- src/wait_counter.sv ----
// Wait-state counter that paces acknowledges to the external master.
`timescale 1ns/1ns
module wait_counter
  import host_access_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  wait_if.counter wif
);
  wait_state_type state_q;
  logic [2:0] cnt_q;
  logic done_q;
  logic zero_left;

  assign zero_left = (cnt_q == 3'h0);
  assign wif.done = done_q;

  // Load on the strobe start, then count down; done fires one cycle after zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= W_IDLE;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        W_IDLE: begin
          if (wif.start) begin
            cnt_q <= wif.waits;
            state_q <= W_COUNT;
          end
        end
        W_COUNT: begin
          if (zero_left) begin
            done_q <= 1'b1;
            state_q <= W_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: state_q <= W_IDLE;
      endcase
    end
  end

  // A request with N waits sees done exactly N + 2 edges after start.
  sequence s_three_waits;
    !wif.done [*4] ##1 wif.done;
  endsequence
  sequence s_zero_waits;
    !wif.done ##1 wif.done;
  endsequence
  sequence s_one_wait;
    !wif.done [*2] ##1 wif.done;
  endsequence

  a_three_wait_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (wif.start && state_q == W_IDLE && wif.waits == ASYNC_WAITS) |=> s_three_waits)
    else $error("Three-wait access did not finish on time.");
  a_zero_wait_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (wif.start && state_q == W_IDLE && wif.waits == SYNC_WRITE_WAITS) |=> s_zero_waits)
    else $error("Zero-wait access did not finish on time.");
  a_one_wait_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (wif.start && state_q == W_IDLE && wif.waits == EXTRA_READ_WAITS) |=> s_one_wait)
    else $error("One-wait read did not finish on time.");
  a_done_single_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    wif.done |=> !wif.done)
    else $error("Done lasted more than one cycle.");
endmodule

// ---- src/slave_mode_host_access.sv ----
// Slave-mode host access: external master port, wait states, bus requests, AXI registers.
`timescale 1ns/1ns
module slave_mode_host_access
  import host_access_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_disable_pin,
  input wire logic bus_strobe_n,
  input wire logic bus_read,
  input wire logic [1:0] bus_addr,
  input wire logic [15:0] bus_data_in,
  output logic [15:0] bus_data_out,
  output logic bus_data_oe,
  output logic data_ack_n,
  output logic core_run,
  input wire logic framed_protocol,
  input wire logic rx_bit_tick,
  input wire logic tx_bit_tick,
  input wire logic serial_dma_grant,
  input wire logic independent_dma_req,
  output logic external_bus_request_n,
  output logic internal_arbiter_request,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import host_access_pkg::*;

  // Pin synchronisers; only the second stage is read by logic. They reset to the
  // idle pin levels, so no false slave entry or strobe follows reset.
  logic [20:0] pin_meta_q;
  logic [20:0] pin_sync_q;
  logic strobe_prev_q, slave_prev_q, slave_mode, strobe_low, ext_read, serial_pending_q;
  logic [1:0] ext_addr;
  logic [15:0] ext_wdata;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= PIN_IDLE;
      pin_sync_q <= PIN_IDLE;
    end else begin
      pin_meta_q <= {core_disable_pin, bus_strobe_n, bus_read, bus_addr, bus_data_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Even synchronous-timing accesses go through the synchronisers: the master's
  // alignment only buys margin, the two synchroniser edges add to the wait counts below.
  assign slave_mode = pin_sync_q[20];
  assign strobe_low = !pin_sync_q[19];
  assign ext_read = pin_sync_q[18];
  assign ext_addr = pin_sync_q[17:16];
  assign ext_wdata = pin_sync_q[15:0];

  // System control register and slave-mode entry.
  logic [1:0] ctrl_q;
  logic slave_entry, sync_access_mode_bit, extra_read_wait_bit;
  assign slave_entry = slave_mode && !slave_prev_q;
  assign sync_access_mode_bit = ctrl_q[SYNC_MODE_POS];
  assign extra_read_wait_bit = ctrl_q[EXTRA_WAIT_POS];

  // Wait count chosen from the timing bits at the moment the strobe falls.
  wait_if wif();
  logic access_start, access_busy_q, ext_write_now;
  logic [2:0] sync_waits;
  assign access_start = slave_mode && strobe_low && strobe_prev_q && !access_busy_q;
  assign sync_waits = ext_read ? (extra_read_wait_bit ? EXTRA_READ_WAITS : SYNC_READ_WAITS)
                               : SYNC_WRITE_WAITS;
  assign wif.start = access_start;
  assign wif.waits = sync_access_mode_bit ? sync_waits : ASYNC_WAITS;
  assign ext_write_now = wif.done && !ext_read;

  wait_counter u_wait (
    .aclk(aclk),
    .aresetn(aresetn),
    .wif(wif)
  );

  // Scratch words reachable by the external master beside the control register.
  logic [15:0] scratch_q [1:3];
  logic [15:0] ext_rdata;
  assign ext_rdata = (ext_addr == EXT_CTRL_ADDR) ? {14'h0000, ctrl_q} : scratch_q[ext_addr];

  // External access front end: acknowledge on done, hold until the strobe rises.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_prev_q <= 1'b1;
      slave_prev_q <= 1'b0;
      access_busy_q <= 1'b0;
      data_ack_n <= 1'b1;
      bus_data_oe <= 1'b0;
      bus_data_out <= 16'h0000;
      core_run <= 1'b1;
      scratch_q[1] <= 16'h0000;
      scratch_q[2] <= 16'h0000;
      scratch_q[3] <= 16'h0000;
    end else begin
      strobe_prev_q <= !strobe_low;
      slave_prev_q <= slave_mode;
      core_run <= !slave_mode;
      if (access_start) begin
        access_busy_q <= 1'b1;
      end
      if (wif.done) begin
        data_ack_n <= 1'b0;
        bus_data_oe <= ext_read;
        bus_data_out <= ext_rdata;
        if (ext_write_now && ext_addr != EXT_CTRL_ADDR) begin
          scratch_q[ext_addr] <= ext_wdata;
        end
      end else if (!strobe_low) begin
        data_ack_n <= 1'b1;
        bus_data_oe <= 1'b0;
        access_busy_q <= 1'b0;
      end
    end
  end

  // AXI4-Lite handshake state.
  logic aw_hs, w_hs, ar_hs;
  logic have_aw_q, have_w_q, do_write;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_ctrl, wr_mapped, rd_mapped;
  logic [31:0] status_word, rd_word;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_write = have_aw_q && have_w_q && !s_axi_bvalid;
  assign wr_ctrl = do_write && awaddr_q == CTRL_OFFSET && wstrb_q[0];
  assign wr_mapped = awaddr_q == CTRL_OFFSET || awaddr_q == STATUS_OFFSET;
  assign rd_mapped = s_axi_araddr == CTRL_OFFSET || s_axi_araddr == STATUS_OFFSET;

  // Control register: slave entry forces asynchronous timing; later writers follow.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (slave_entry) begin
      ctrl_q <= CTRL_RESET;
    end else if (ext_write_now && ext_addr == EXT_CTRL_ADDR) begin
      ctrl_q <= ext_wdata[1:0];
    end else if (wr_ctrl) begin
      ctrl_q <= wdata_q[1:0];
    end
  end

  // Write channel: address and data taken in either order, one response each.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
        have_aw_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        have_w_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: one-cycle answer, status shows live block state.
  assign status_word = {29'h0, independent_dma_req, serial_pending_q, slave_mode};
  assign rd_word = (s_axi_araddr == CTRL_OFFSET) ? {30'h0, ctrl_q} : status_word;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mapped ? rd_word : 32'h00000000;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Serial DMA pacing: bit counters raise a memory-cycle request. These never look
  // at the slave timing bits, so DMA cycles keep their own speed.
  logic [4:0] rx_cnt_q;
  logic [4:0] tx_cnt_q;
  logic [4:0] rx_limit;
  logic rx_due, tx_due;
  assign rx_limit = framed_protocol ? FRAMED_BITS : OTHER_RX_BITS;
  assign rx_due = rx_bit_tick && (rx_cnt_q + 5'h01 >= rx_limit);
  assign tx_due = tx_bit_tick && (tx_cnt_q + 5'h01 >= OTHER_TX_BITS);

  // A new request in the grant cycle wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt_q <= 5'h00;
      tx_cnt_q <= 5'h00;
      serial_pending_q <= 1'b0;
    end else begin
      if (rx_bit_tick) begin
        rx_cnt_q <= rx_due ? 5'h00 : rx_cnt_q + 5'h01;
      end
      if (tx_bit_tick) begin
        tx_cnt_q <= tx_due ? 5'h00 : tx_cnt_q + 5'h01;
      end
      if (rx_due || tx_due) begin
        serial_pending_q <= 1'b1;
      end else if (serial_dma_grant) begin
        serial_pending_q <= 1'b0;
      end
    end
  end

  // Route DMA requests to the pin in slave mode, else to the on-chip arbiter.
  logic dma_want;
  assign dma_want = serial_pending_q || independent_dma_req;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_bus_request_n <= 1'b1;
      internal_arbiter_request <= 1'b0;
    end else begin
      external_bus_request_n <= !(dma_want && slave_mode);
      internal_arbiter_request <= dma_want && !slave_mode;
    end
  end

  a_entry_forces_async: assert property (@(posedge aclk) disable iff (!aresetn)
    slave_entry |=> !sync_access_mode_bit && !extra_read_wait_bit)
    else $error("Slave entry did not restore asynchronous timing.");
  a_ext_request_slave: assert property (@(posedge aclk) disable iff (!aresetn)
    (dma_want && slave_mode) |=> !external_bus_request_n)
    else $error("Slave-mode DMA request did not reach the pin.");
  a_no_ext_outside: assert property (@(posedge aclk) disable iff (!aresetn)
    !slave_mode |=> external_bus_request_n)
    else $error("Bus request pin moved outside slave mode.");
  a_core_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
    slave_mode |=> !core_run)
    else $error("Core still running in slave mode.");
  a_ack_follows_done: assert property (@(posedge aclk) disable iff (!aresetn)
    wif.done |=> !data_ack_n ##1 (!data_ack_n || !strobe_low))
    else $error("Acknowledge did not follow the counted waits.");
  a_async_ack_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    (access_start && !sync_access_mode_bit) |=> data_ack_n [*5] ##1 !data_ack_n)
    else $error("Asynchronous access not acknowledged after three waits.");
endmodule

// ---- tb/ext_master_model.sv ----
// Behavioural external master that drives the host bus of the slave device.
`timescale 1ns/1ns
module ext_master_model (
  input wire logic aclk,
  output logic bus_strobe_n,
  output logic bus_read,
  output logic [1:0] bus_addr,
  output logic [15:0] bus_data_in,
  input wire logic [15:0] bus_data_out,
  input wire logic bus_data_oe,
  input wire logic data_ack_n
);
  // Idle bus at time zero, strobe released.
  initial begin
    bus_strobe_n = 1'b1;
    bus_read = 1'b1;
    bus_addr = 2'h0;
    bus_data_in = 16'h5a5a;
  end

  // One word access; cyc is the edge count from driving the strobe to seeing the acknowledge.
  // Signals move just after an edge, which suits both timings.
  // The model shares the slave clock, as the master clock should feed the slave.
  task automatic access(input logic rd, input logic [1:0] a, input logic [15:0] wd,
                        output logic [15:0] q, output logic oe, output int cyc);
    cyc = -1;
    q = 16'h0;
    oe = 1'b0;
    @(posedge aclk);
    bus_read <= rd;
    bus_addr <= a;
    bus_data_in <= rd ? ~bus_data_in : wd;
    bus_strobe_n <= 1'b0;
    for (int i = 1; i < 60 && cyc < 0; i++) begin
      @(posedge aclk);
      if (data_ack_n === 1'b0) begin
        cyc = i;
        q = bus_data_out;
        oe = bus_data_oe;
      end
    end
    // Released data lines show the inverse, so a stale value cannot pass.
    bus_strobe_n <= 1'b1;
    bus_data_in <= ~bus_data_in;
    for (int i = 0; i < 20 && data_ack_n !== 1'b1; i++) @(posedge aclk);
  endtask
endmodule

// ---- tb/slave_mode_host_access_tb.sv ----
// Self-checking bench for the slave-mode host access block.
`timescale 1ns/1ns
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module slave_mode_host_access_tb;
  import host_access_pkg::*;
  // Edges from strobe drive to seen acknowledge beyond the wait states: sync 2, start 1, ack 3.
  localparam int OVH = 6;
  logic aclk, aresetn, core_disable_pin, bus_strobe_n, bus_read, bus_data_oe, data_ack_n;
  logic [1:0] bus_addr;
  logic [15:0] bus_data_in, bus_data_out, q;
  logic oe_seen;
  logic core_run, framed_protocol, rx_bit_tick, tx_bit_tick;
  logic serial_dma_grant, independent_dma_req;
  logic external_bus_request_n, internal_arbiter_request;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] mem [4];
  int bad_count = 0;
  int total_checks = 0;
  int cyc;
  int cases [4][3] = '{'{1, 0, 16}, '{1, 1, 16}, '{0, 1, 8}, '{0, 0, 16}};

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  slave_mode_host_access i_dut (.aclk, .aresetn, .core_disable_pin, .bus_strobe_n, .bus_read,
    .bus_addr, .bus_data_in, .bus_data_out, .bus_data_oe, .data_ack_n, .core_run,
    .framed_protocol, .rx_bit_tick, .tx_bit_tick, .serial_dma_grant, .independent_dma_req,
    .external_bus_request_n, .internal_arbiter_request, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  ext_master_model i_master (.aclk, .bus_strobe_n, .bus_read, .bus_addr, .bus_data_in,
    .bus_data_out, .bus_data_oe, .data_ack_n);

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A wait that ran out is a mismatch and closes the run.
  task automatic hang;
    bad_count++;
    $display("CHECK FAILED %0t timeout", $time);
    report_and_stop();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // AXI write: address and data offered together, each dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 50) hang();
  endtask

  // AXI read: address held until taken, rready held until rvalid is sampled.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 50) hang();
  endtask

  // Master access checked against the scratch model and the expected wait count.
  task automatic acc(input logic r, input logic [1:0] a, input logic [15:0] wd, input int n);
    i_master.access(r, a, wd, q, oe_seen, cyc);
    if (cyc < 0) hang();
    `CHK(cyc, n + OVH, "wait states")
    `CHK(oe_seen, r, "drive enable")
    if (r) `CHK(q, mem[a], "read data")
    else mem[a] = wd;
  endtask

  // Bit ticks as separate one-cycle pulses on the receive or transmit side.
  task automatic bits(input logic rx, input int n);
    repeat (n) begin
      @(posedge aclk);
      rx_bit_tick <= rx;
      tx_bit_tick <= !rx;
      @(posedge aclk);
      rx_bit_tick <= 1'b0;
      tx_bit_tick <= 1'b0;
    end
  endtask

  initial begin
    {aresetn, core_disable_pin, framed_protocol, rx_bit_tick, tx_bit_tick} = '0;
    {serial_dma_grant, independent_dma_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    rd = $urandom(12595);
    tick(3);
    aresetn <= 1'b1;
    tick(2);
    `CHK(core_run, 1'b1, "core runs")
    axi_rd(CTRL_OFFSET, rd, rs);
    `CHK(rd[1:0], CTRL_RESET, "control reset")
    axi_rd(8'hf0, rd, rs);
    `CHK(rs, RESP_SLVERR, "unmapped read")
    independent_dma_req <= 1'b1;
    tick(8);
    `CHK({internal_arbiter_request, external_bus_request_n}, 2'h3, "internal arbiter")
    axi_rd(STATUS_OFFSET, rd, rs);
    `CHK({rd[ST_INDEP_POS], rd[ST_SLAVE_POS]}, 2'h2, "status normal")
    $display("test normal mode done");
    core_disable_pin <= 1'b1;
    tick(8);
    `CHK(core_run, 1'b0, "core stopped")
    `CHK({internal_arbiter_request, external_bus_request_n}, 2'h0, "external request")
    independent_dma_req <= 1'b0;
    tick(8);
    `CHK(external_bus_request_n, 1'b1, "request released")
    for (int i = 1; i < 4; i++) begin
      acc(1'b0, 2'(i), 16'($urandom), ASYNC_WAITS);
      acc(1'b1, 2'(i), 16'h0, ASYNC_WAITS);
    end
    $display("test async done");
    axi_wr(CTRL_OFFSET, 32'h1, rs);
    `CHK(rs, RESP_OKAY, "control write")
    acc(1'b0, 2'h1, 16'($urandom), SYNC_WRITE_WAITS);
    acc(1'b1, 2'h1, 16'h0, SYNC_READ_WAITS);
    axi_wr(CTRL_OFFSET, 32'h3, rs);
    acc(1'b0, 2'h2, 16'($urandom), SYNC_WRITE_WAITS);
    acc(1'b1, 2'h2, 16'h0, EXTRA_READ_WAITS);
    $display("test sync done");
    // Every protocol and direction pair, counted to one short and then to the boundary.
    foreach (cases[k]) begin
      framed_protocol <= 1'(cases[k][0]);
      bits(1'(cases[k][1]), cases[k][2] - 1);
      axi_rd(STATUS_OFFSET, rd, rs);
      `CHK(rd[ST_SERIAL_POS], 1'b0, "pending early")
      bits(1'(cases[k][1]), 1);
      axi_rd(STATUS_OFFSET, rd, rs);
      `CHK(rd[ST_SERIAL_POS], 1'b1, "pending at count")
      `CHK(rd[ST_SLAVE_POS], 1'b1, "slave status")
      `CHK(external_bus_request_n, 1'b0, "serial request")
      @(posedge aclk);
      serial_dma_grant <= 1'b1;
      @(posedge aclk);
      serial_dma_grant <= 1'b0;
      tick(3);
      `CHK(external_bus_request_n, 1'b1, "grant clears")
    end
    $display("test serial dma done");
    core_disable_pin <= 1'b0;
    tick(8);
    `CHK(core_run, 1'b1, "core resumes")
    core_disable_pin <= 1'b1;
    tick(8);
    acc(1'b1, 2'h3, 16'h0, ASYNC_WAITS);
    $display("test reentry done");
    report_and_stop();
  end
endmodule
